// [inc/sram_fifo_pkg.sv]
// constants and register map of the block ram fifo
// Operation
// - non-pipelined read registers the data at the read edge and shows it after that one edge
// - pipelined read registers the data in a stage, then in the output; data shows after the second edge
// - pipeline option on selects pipelined timing, off selects single-edge timing
// - each clock edge with write enable high, full low and no serial load selected stores the write word at the address
// - serial test-port path loads all 4,608 content bits in one operation
// - empty-count stop high holds the read counter while empty is high
// - full-count stop high holds the write counter while full is high
// - full flag high when no more words fit; blocks writes at once
// - full compares against a delayed read pointer; clears two edges after the read
// - empty flag high when nothing to read; does not block the array read, read data is still presented
// - empty compares against a delayed write pointer; clears two edges after the write
// - address counters start at zero, count to depth minus one, then wrap
// - separate 12-bit write and read counters advance on each enabled access unless held by their count stop
// - almost-full high while write minus read count, as data bits, reaches the almost-full threshold
// - almost-empty high while write minus read count, as data bits, is at or below its threshold
package sram_fifo_pkg;
    localparam int DATA_W_DEF  = 9;
    localparam int DEPTH_DEF   = 512;
    localparam int PTR_W       = 12;
    localparam int THR_W       = 12;
    localparam int BITS_W      = 24;
    localparam int HADDR_W     = 32;
    localparam int HDATA_W     = 32;
    localparam int REG_SEL_LSB = 2;
    localparam int REG_SEL_W   = 4;

    // register word offsets
    localparam logic [HADDR_W-1:0] OFS_CTRL   = 32'h0000_0000;
    localparam logic [HADDR_W-1:0] OFS_THRESH = 32'h0000_0004;
    localparam logic [HADDR_W-1:0] OFS_STATUS = 32'h0000_0008;
    localparam logic [HADDR_W-1:0] OFS_PTRS   = 32'h0000_000C;

    // control fields
    localparam int CTRL_PIPE_BIT  = 0;
    localparam int CTRL_EMPTY_COUNT_STOP_BIT = 1;
    localparam int CTRL_FULL_COUNT_STOP_BIT = 2;
    // threshold fields
    localparam int THR_AF_LSB = 0;
    localparam int THR_AE_LSB = 16;
    // status fields
    localparam int ST_EMPTY_BIT  = 0;
    localparam int ST_FULL_BIT   = 1;
    localparam int ST_ALMOST_EMPTY_FLAG_BIT = 2;
    localparam int ST_ALMOST_FULL_FLAG_BIT  = 3;
    localparam int ST_INIT_BIT   = 4;
    // pointer fields
    localparam int PTR_W_LSB = 0;
    localparam int PTR_R_LSB = 16;

    localparam logic [THR_W-1:0]   AF_THR_RST = 12'h000;
    localparam logic [THR_W-1:0]   AE_THR_RST = 12'h000;
    localparam logic [HDATA_W-1:0] HRDATA_RST = 32'h0000_0000;
    localparam logic [1:0]         HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic               HRESP_OKAY = 1'b0;
endpackage

// [inc/ram_port_if.sv]
// port bundle between the fifo control and its ram array
`timescale 1ns/1ps
interface ram_port_if #(
    parameter int AW = 9,
    parameter int DW = 9
);
    logic          wen;
    logic [AW-1:0] write_pointer;
    logic [DW-1:0] wdata;
    logic          ren;
    logic [AW-1:0] read_addr_in;
    logic          pipe;
    logic [DW-1:0] rdata;

    modport ctrl (output wen, write_pointer, wdata, ren, read_addr_in, pipe, input rdata);
    modport mem  (input wen, write_pointer, wdata, ren, read_addr_in, pipe, output rdata);
endinterface

// [hdl/ram_array.sv]
// dual-port ram array with registered read data and optional pipeline stage
`timescale 1ns/1ps
module ram_array #(
    parameter int AW    = 9,
    parameter int DW    = 9,
    parameter int DEPTH = 512
) (
    input  wire logic   clk,
    input  wire logic   rst,
    ram_port_if.mem     port
);
    import sram_fifo_pkg::*;

    typedef struct packed {
        logic [DW-1:0] stage;
        logic [DW-1:0] q;
    } mem_state_s;

    mem_state_s    st;
    mem_state_s    next_st;
    logic [DW-1:0] array_q [DEPTH];

    always_ff @(posedge clk) begin
        if (port.wen) begin
            array_q[port.write_pointer] <= port.wdata;
        end
    end

    always_comb begin
        next_st = st;
        if (port.pipe) begin
            // address edge loads the stage, the next edge moves it out
            if (port.ren) begin
                next_st.stage = array_q[port.read_addr_in];
            end
            next_st.q = st.stage;
        end else if (port.ren) begin
            next_st.q = array_q[port.read_addr_in];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.rdata = st.q;
endmodule

// [hdl/sram_fifo_block.sv]
// block ram fifo with flags, serial init path and ahb-lite control registers
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module sram_fifo_block #(
    parameter int DATA_W = sram_fifo_pkg::DATA_W_DEF,
    parameter int DEPTH  = sram_fifo_pkg::DEPTH_DEF
) (
    input  wire logic                               CORE_CLK,
    input  wire logic                               SYS_RST,
    input  wire logic                               HSEL,
    input  wire logic [sram_fifo_pkg::HADDR_W-1:0]  HADDR,
    input  wire logic [1:0]                         HTRANS,
    input  wire logic                               HWRITE,
    input  wire logic [2:0]                         HSIZE,
    input  wire logic [sram_fifo_pkg::HDATA_W-1:0]  HWDATA,
    input  wire logic                               HREADY,
    output logic      [sram_fifo_pkg::HDATA_W-1:0]  HRDATA,
    output logic                                    HREADYOUT,
    output logic                                    HRESP,
    input  wire logic                               WR_EN,
    input  wire logic [DATA_W-1:0]                  WR_DATA,
    input  wire logic                               RD_EN,
    output logic      [DATA_W-1:0]                  RD_DATA,
    output logic                                    FULL,
    output logic                                    EMPTY,
    output logic                                    ALMOST_FULL,
    output logic                                    ALMOST_EMPTY,
    input  wire logic                               INIT_SEL,
    input  wire logic                               INIT_SHIFT,
    input  wire logic                               INIT_BIT
);
    import sram_fifo_pkg::*;

    localparam int AW    = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DATA_W) + 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(DATA_W - 1);

    typedef struct packed {
        logic [PTR_W-1:0]   wptr;
        logic               wlap;
        logic [PTR_W-1:0]   rptr;
        logic               rlap;
        logic [PTR_W-1:0]   wsync;
        logic               wsync_lap;
        logic [PTR_W-1:0]   rsync;
        logic               rsync_lap;
        logic               full;
        logic               empty;
        logic               almost_full_flag;
        logic               almost_empty_flag;
        logic               pipe;
        logic               empty_count_stop;
        logic               full_count_stop;
        logic [THR_W-1:0]   almost_full_flag_thr;
        logic [THR_W-1:0]   almost_empty_flag_thr;
        logic               sel_m;
        logic               sel_s;
        logic               sel_d;
        logic               shift_m;
        logic               shift_s;
        logic               shift_d;
        logic               bit_m;
        logic               bit_s;
        logic [DATA_W-1:0]  init_word;
        logic [CNT_W-1:0]   init_cnt;
        logic [AW-1:0]      init_addr;
        logic               ahb_wr;
        logic [REG_SEL_W-1:0] ahb_reg;
        logic [HDATA_W-1:0] hrdata;
        logic               hreadyout;
    } state_s;

    state_s st;
    state_s next_st;
    ram_port_if #(.AW(AW), .DW(DATA_W)) ram_bus ();

    ram_array #(
        .AW    (AW),
        .DW    (DATA_W),
        .DEPTH (DEPTH)
    ) u_array (
        .clk  (CORE_CLK),
        .rst  (SYS_RST),
        .port (ram_bus.mem)
    );

    // advance a counter, wrapping at the last entry and flipping its lap bit
    function automatic logic [PTR_W:0] ptr_step(input logic [PTR_W-1:0] p, input logic lap);
        if (p == PTR_LAST) begin
            ptr_step = {~lap, {PTR_W{1'b0}}};
        end else begin
            ptr_step = {lap, p + PTR_W'(1)};
        end
    endfunction

    // words held, expressed as data bits
    function automatic logic [BITS_W-1:0] held_bits(input logic [PTR_W-1:0] w, input logic wl,
                                                   input logic [PTR_W-1:0] r, input logic rl);
        logic [PTR_W:0] words;
        words = '0;
        if (wl == rl) begin
            words = {1'b0, w} - {1'b0, r};
        end else begin
            words = (PTR_W+1)'(DEPTH) + {1'b0, w} - {1'b0, r};
        end
        held_bits = BITS_W'(words) * BITS_W'(DATA_W);
    endfunction

    logic             init_write;
    logic             wr_take;
    logic             rd_take;
    logic             wr_advance;
    logic             rd_advance;
    logic [PTR_W:0]   w_next;
    logic [PTR_W:0]   r_next;
    logic             ahb_go;
    logic [REG_SEL_W-1:0] addr_reg;
    logic [HDATA_W-1:0]   rd_value;

    always_comb begin
        next_st = st;

        // test-port pins come from another domain: two flops first
        next_st.sel_m   = INIT_SEL;
        next_st.sel_s   = st.sel_m;
        next_st.sel_d   = st.sel_s;
        next_st.shift_m = INIT_SHIFT;
        next_st.shift_s = st.shift_m;
        next_st.shift_d = st.shift_s;
        next_st.bit_m   = INIT_BIT;
        next_st.bit_s   = st.bit_m;

        // serial load, lsb first, one word written per data width of bits
        init_write = 1'b0;
        if (st.sel_s && !st.sel_d) begin
            next_st.init_cnt  = '0;
            next_st.init_addr = '0;
        end else if (st.sel_s && st.shift_s && !st.shift_d) begin
            next_st.init_word = {st.bit_s, st.init_word[DATA_W-1:1]};
            if (st.init_cnt == BIT_LAST) begin
                init_write        = 1'b1;
                next_st.init_cnt  = '0;
                next_st.init_addr = st.init_addr + AW'(1);
            end else begin
                next_st.init_cnt = st.init_cnt + CNT_W'(1);
            end
        end

        // accesses: array write blocked when full, read data always presented
        wr_take    = WR_EN && !st.sel_s && !st.full;
        rd_take    = RD_EN;
        wr_advance = WR_EN && !st.sel_s && (!st.full || !st.full_count_stop);
        rd_advance = RD_EN && (!st.empty || !st.empty_count_stop);

        w_next = wr_advance ? ptr_step(st.wptr, st.wlap) : {st.wlap, st.wptr};
        r_next = rd_advance ? ptr_step(st.rptr, st.rlap) : {st.rlap, st.rptr};
        next_st.wlap = w_next[PTR_W];
        next_st.wptr = w_next[PTR_W-1:0];
        next_st.rlap = r_next[PTR_W];
        next_st.rptr = r_next[PTR_W-1:0];

        // one-flop resynchronised copies feed the flag registers
        next_st.wsync     = st.wptr;
        next_st.wsync_lap = st.wlap;
        next_st.rsync     = st.rptr;
        next_st.rsync_lap = st.rlap;

        next_st.full  = (w_next[PTR_W-1:0] == st.rsync) && (w_next[PTR_W] != st.rsync_lap);
        next_st.empty = (r_next[PTR_W-1:0] == st.wsync) && (r_next[PTR_W] == st.wsync_lap);
        next_st.almost_full_flag = held_bits(w_next[PTR_W-1:0], w_next[PTR_W], st.rsync, st.rsync_lap)
                        >= BITS_W'(st.almost_full_flag_thr);
        next_st.almost_empty_flag = held_bits(st.wsync, st.wsync_lap, r_next[PTR_W-1:0], r_next[PTR_W])
                         <= BITS_W'(st.almost_empty_flag_thr);

        // ahb-lite slave: zero wait states, always okay
        ahb_go   = HSEL && HTRANS[1] && HREADY;
        addr_reg = HADDR[REG_SEL_LSB +: REG_SEL_W];
        rd_value = '0;
        case (addr_reg)
            OFS_CTRL[REG_SEL_LSB +: REG_SEL_W]: begin
                rd_value[CTRL_PIPE_BIT]  = st.pipe;
                rd_value[CTRL_EMPTY_COUNT_STOP_BIT] = st.empty_count_stop;
                rd_value[CTRL_FULL_COUNT_STOP_BIT] = st.full_count_stop;
            end
            OFS_THRESH[REG_SEL_LSB +: REG_SEL_W]: begin
                rd_value[THR_AF_LSB +: THR_W] = st.almost_full_flag_thr;
                rd_value[THR_AE_LSB +: THR_W] = st.almost_empty_flag_thr;
            end
            OFS_STATUS[REG_SEL_LSB +: REG_SEL_W]: begin
                rd_value[ST_EMPTY_BIT]  = st.empty;
                rd_value[ST_FULL_BIT]   = st.full;
                rd_value[ST_ALMOST_EMPTY_FLAG_BIT] = st.almost_empty_flag;
                rd_value[ST_ALMOST_FULL_FLAG_BIT]  = st.almost_full_flag;
                rd_value[ST_INIT_BIT]   = st.sel_s;
            end
            OFS_PTRS[REG_SEL_LSB +: REG_SEL_W]: begin
                rd_value[PTR_W_LSB +: PTR_W] = st.wptr;
                rd_value[PTR_R_LSB +: PTR_W] = st.rptr;
            end
            default: begin
                rd_value = '0;
            end
        endcase
        if (HADDR[HADDR_W-1:REG_SEL_LSB + REG_SEL_W] != '0) begin
            rd_value = '0;
        end

        next_st.ahb_wr  = ahb_go && HWRITE && (HADDR[HADDR_W-1:REG_SEL_LSB + REG_SEL_W] == '0);
        next_st.ahb_reg = addr_reg;
        if (ahb_go && !HWRITE) begin
            next_st.hrdata = rd_value;
        end
        next_st.hreadyout = 1'b1;

        // data phase of a write
        if (st.ahb_wr) begin
            case (st.ahb_reg)
                OFS_CTRL[REG_SEL_LSB +: REG_SEL_W]: begin
                    next_st.pipe  = HWDATA[CTRL_PIPE_BIT];
                    next_st.empty_count_stop = HWDATA[CTRL_EMPTY_COUNT_STOP_BIT];
                    next_st.full_count_stop = HWDATA[CTRL_FULL_COUNT_STOP_BIT];
                end
                OFS_THRESH[REG_SEL_LSB +: REG_SEL_W]: begin
                    next_st.almost_full_flag_thr  = HWDATA[THR_AF_LSB +: THR_W];
                    next_st.almost_empty_flag_thr = HWDATA[THR_AE_LSB +: THR_W];
                end
                default: begin
                    next_st.pipe = st.pipe;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st            <= '0;
            st.empty      <= 1'b1;
            st.almost_empty_flag     <= 1'b1;
            st.almost_full_flag_thr  <= AF_THR_RST;
            st.almost_empty_flag_thr <= AE_THR_RST;
            st.hrdata     <= HRDATA_RST;
            st.hreadyout  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ram port: the serial load owns the write port while selected
    assign ram_bus.wen          = init_write || wr_take;
    assign ram_bus.write_pointer        = init_write ? st.init_addr : st.wptr[AW-1:0];
    assign ram_bus.wdata        = init_write ? {st.bit_s, st.init_word[DATA_W-1:1]} : WR_DATA;
    assign ram_bus.ren          = rd_take;
    assign ram_bus.read_addr_in = st.rptr[AW-1:0];
    assign ram_bus.pipe         = st.pipe;

    assign RD_DATA      = ram_bus.rdata;
    assign FULL         = st.full;
    assign EMPTY        = st.empty;
    assign ALMOST_FULL  = st.almost_full_flag;
    assign ALMOST_EMPTY = st.almost_empty_flag;
    assign HRDATA       = st.hrdata;
    assign HREADYOUT    = st.hreadyout;
    assign HRESP        = HRESP_OKAY;
endmodule

// [tb/fifo_user_model.sv]
// user fabric model on the fifo write and read ports
`timescale 1ns/1ps
module fifo_user_model #(
    parameter int W = 9
) (
    input  wire logic         push,
    input  wire logic [W-1:0] word,
    input  wire logic         pop,
    output logic              wr_en,
    output logic      [W-1:0] wr_data,
    output logic              rd_en
);
    // an idle write bus shows the inverse of its last word
    assign wr_data = push ? word : ~word;
    assign wr_en   = push;
    assign rd_en   = pop;
endmodule

// [tb/sram_fifo_props.sv]
// checker for flags, stop controls and reset state of the fifo
`timescale 1ns/1ps
module sram_fifo_props (
    input wire logic                              CORE_CLK,
    input wire logic                              SYS_RST,
    input wire logic                              HSEL,
    input wire logic [sram_fifo_pkg::HADDR_W-1:0] HADDR,
    input wire logic [1:0]                        HTRANS,
    input wire logic                              HWRITE,
    input wire logic [sram_fifo_pkg::HDATA_W-1:0] HWDATA,
    input wire logic                              HREADY,
    input wire logic                              WR_EN,
    input wire logic                              RD_EN,
    input wire logic                              FULL,
    input wire logic                              EMPTY,
    input wire logic                              ALMOST_FULL,
    input wire logic                              ALMOST_EMPTY
);
    import sram_fifo_pkg::*;
    logic [1:0] hw;
    logic [1:0] hr;
    logic [2:0] ctl;
    logic       ap;
    logic       quiet;
    // no fifo access in the two previous cycles
    assign quiet = hw == 2'h0 && hr == 2'h0;
    always_ff @(posedge CORE_CLK) begin
        hw <= {hw[0], WR_EN};
        hr <= {hr[0], RD_EN};
        if (SYS_RST) begin
            ap  <= 1'b0;
            ctl <= 3'h0;
        end else if (HREADY) begin
            ap <= HSEL && HTRANS[1] && HWRITE && HADDR == OFS_CTRL;
            if (ap) begin
                ctl <= HWDATA[2:0];
            end
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    chk_rst_flags: assert property ($fell(SYS_RST) |-> EMPTY && ALMOST_EMPTY && !FULL && !ALMOST_FULL)
        else $error("flags wrong after reset");
    chk_empty_stays: assert property (quiet && EMPTY && WR_EN && !RD_EN |=> EMPTY [*2])
        else $error("empty fell too early");
    chk_empty_clears: assert property (quiet && EMPTY && WR_EN && !RD_EN ##1 !RD_EN [*2] |=> !EMPTY)
        else $error("empty did not fall");
    chk_full_stays: assert property (quiet && FULL && RD_EN && !WR_EN |=> FULL [*2])
        else $error("full fell too early");
    chk_full_clears: assert property (quiet && FULL && RD_EN && !WR_EN ##1 !WR_EN [*2] |=> !FULL)
        else $error("full did not fall");
    chk_empty_count_stop_hold: assert property (ctl[CTRL_EMPTY_COUNT_STOP_BIT] && quiet && EMPTY && RD_EN && !WR_EN |=> EMPTY)
        else $error("read past empty with stop on");
    chk_full_count_stop_hold: assert property (ctl[CTRL_FULL_COUNT_STOP_BIT] && quiet && FULL && WR_EN && !RD_EN |=> FULL)
        else $error("write past full with stop on");
    chk_flags_apart: assert property (!(EMPTY && FULL))
        else $error("empty and full together");
    cover property (FULL && RD_EN);
    cover property (ctl[CTRL_EMPTY_COUNT_STOP_BIT] && EMPTY && RD_EN);
    cover property (ctl[CTRL_PIPE_BIT] && RD_EN);
endmodule
bind sram_fifo_block sram_fifo_props u_props (.CORE_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
    .HREADY, .WR_EN, .RD_EN, .FULL, .EMPTY, .ALMOST_FULL, .ALMOST_EMPTY);

// [tb/sram_fifo_block_tb_top.sv]
// self-checking bench of the block ram fifo
`timescale 1ns/1ps
module sram_fifo_block_tb_top;
    import sram_fifo_pkg::*;
    logic        CORE_CLK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, HREADY, HREADYOUT, HRESP;
    logic        push = 1'b0, pop = 1'b0, INIT_SEL = 1'b0, INIT_SHIFT = 1'b0, INIT_BIT = 1'b0;
    logic        WR_EN, RD_EN, FULL, EMPTY, ALMOST_FULL, ALMOST_EMPTY, pipe = 1'b0, t1 = 1'b0, t2 = 1'b0;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  ctl = 3'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, r, lf = 32'h0001_78DB;
    logic [8:0]  word = 9'h000, WR_DATA, RD_DATA, mem [512], exq [$];
    int          n_errors = 0, compares = 0, wp = 0, rp = 0, cnt = 0, i;
    assign HREADY = HREADYOUT;
    initial forever #12.5 CORE_CLK = ~CORE_CLK;
    sram_fifo_block u_dut (.CORE_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY,
        .HRDATA, .HREADYOUT, .HRESP, .WR_EN, .WR_DATA, .RD_EN, .RD_DATA, .FULL, .EMPTY, .ALMOST_FULL,
        .ALMOST_EMPTY, .INIT_SEL, .INIT_SHIFT, .INIT_BIT);
    fifo_user_model u_user (.push, .word, .pop, .wr_en(WR_EN), .wr_data(WR_DATA), .rd_en(RD_EN));
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    task automatic hwait;
        for (int k = 0; HREADYOUT !== 1'b1; k++) begin
            if (k > 40) begin
                n_errors++;
                results;
            end
            tick(1);
        end
    endtask
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= HTRANS_NONSEQ_BIT;
        HADDR <= a;
        HWRITE <= w;
        tick(1);
        hwait;
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        tick(1);
        hwait;
        r = HRDATA;
        check(HRESP, HRESP_OKAY);
    endtask
    task automatic wctl(logic [2:0] c);
        bus(1'b1, OFS_CTRL, {29'h0, c});
        ctl = c;
        pipe = c[CTRL_PIPE_BIT];
        tick(2);
    endtask
    task automatic pushn(int n);
        repeat (n) begin
            lf = nxt(lf);
            push <= 1'b1;
            word <= lf[8:0];
            // a full fifo drops the word
            if (cnt < 512) begin
                mem[wp] = lf[8:0];
                wp = (wp + 1) % 512;
                cnt++;
            end
            tick(1);
        end
        push <= 1'b0;
    endtask
    task automatic popn(int n);
        repeat (n) begin
            pop <= 1'b1;
            exq.push_back(mem[rp]);
            if (cnt > 0 || !ctl[CTRL_EMPTY_COUNT_STOP_BIT]) begin
                rp = (rp + 1) % 512;
            end
            if (cnt > 0) begin
                cnt--;
            end
            tick(1);
        end
        pop <= 1'b0;
    endtask
    always @(posedge CORE_CLK) begin
        t1 <= RD_EN;
        t2 <= t1 && pipe;
    end
    always @(negedge CORE_CLK) begin
        if ((pipe ? t2 : t1) && exq.size() > 0) begin
            check(RD_DATA, exq.pop_front());
        end
    end
    initial begin
        tick(60000);
        n_errors++;
        results;
    end
    initial begin
        tick(6);
        // flags are looked at while reset still holds them, away from the release edge
        check({EMPTY, ALMOST_EMPTY, FULL, ALMOST_FULL}, 4'hC);
        SYS_RST <= 1'b0;
        tick(1);
        bus(1'b0, OFS_PTRS, 32'h0);
        check(r, 32'h0);
        bus(1'b0, 32'h0000_0010, 32'h0);
        check(r, 32'h0);
        bus(1'b1, OFS_THRESH, 32'h0012_0024);
        bus(1'b0, OFS_THRESH, 32'h0);
        check(r, 32'h0012_0024);
        pushn(3);
        tick(4);
        check({ALMOST_EMPTY, ALMOST_FULL}, 2'h0);
        pushn(1);
        tick(4);
        check({ALMOST_EMPTY, ALMOST_FULL}, 2'h1);
        popn(2);
        tick(4);
        check({ALMOST_EMPTY, ALMOST_FULL}, 2'h2);
        bus(1'b0, OFS_PTRS, 32'h0);
        check(r, 32'h0002_0004);
        popn(2);
        wctl(3'h1);
        pushn(2);
        tick(4);
        popn(2);
        tick(4);
        wctl(3'h4);
        pushn(512);
        tick(4);
        check(FULL, 1'b1);
        pushn(1);
        tick(4);
        popn(512);
        tick(4);
        check(EMPTY, 1'b1);
        wctl(3'h2);
        popn(1);
        tick(4);
        check(EMPTY, 1'b1);
        pushn(1);
        tick(4);
        popn(1);
        wctl(3'h0);
        pushn(1);
        tick(4);
        popn(3);
        tick(4);
        SYS_RST <= 1'b1;
        tick(2);
        check({EMPTY, ALMOST_EMPTY, FULL, ALMOST_FULL}, 4'hC);
        SYS_RST <= 1'b0;
        {wp, rp, cnt} = '0;
        tick(1);
        INIT_SEL <= 1'b1;
        tick(4);
        for (i = 0; i < 4608; i++) begin
            lf = nxt(lf);
            INIT_BIT <= lf[0];
            mem[i / 9][i % 9] = lf[0];
            tick(3);
            INIT_SHIFT <= 1'b1;
            tick(3);
            INIT_SHIFT <= 1'b0;
        end
        tick(4);
        INIT_SEL <= 1'b0;
        tick(4);
        popn(2);
        tick(6);
        check(exq.size(), 0);
        results;
    end
endmodule
